// >>> rtl/mss_signal_top.sv
// Status signalling pads, level output and analog read control
//
// What this block does
// - Inhibit pad low in alternate mode keeps the transmitter disabled.
// - Monitor pad has two modes: whole call or per burst.
// - Whole-call mode: monitor rises 300ms before first burst, stays high.
// - Whole-call mode: monitor falls 500ms to 1s after last burst.
// - Burst mode: monitor follows transmitter bursts directly.
// - Alarm pad rises on alarm, stays high until software clears it.
// - Tone pad drives square waves for an external buzzer driver.
// - Status pin is inverted relative to the lamp state.
// - Lamp off when device off, on while a call is active.
// - Search, unregistered or shutting down: 1s period, 0.5s on.
// - Registered, no call: 3s period, 0.3s on.
// - Level output is a 10-bit function of a 0..1023 setting.
// - Pulse average equals 2*value/1023 volts after filtering.
// - Pulse frequency fixed internally, not host selectable.
// - Two analog inputs, either selectable for a conversion.
// - Each conversion is sampled, held and gives an 11-bit word.
// - Reported result is in millivolts, not raw counts.
// - Pads set as outputs drive both high and low.
// - Each pad is input, output or alternate function.
`timescale 1ns/1ps
module mss_signal_top #(
    parameter int TICK_CYC = mss_pkg::TICK_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // General-purpose pads: inhibit, monitor, alarm, tone
    input wire logic [mss_pkg::NPAD-1:0] pad_i,
    output logic [mss_pkg::NPAD-1:0] pad_o,
    output logic [mss_pkg::NPAD-1:0] pad_oe_o,
    // Device-internal status
    input wire logic dev_on_i,
    input wire logic call_active_i,
    input wire logic [1:0] net_state_i,
    input wire logic tx_burst_i,
    input wire logic alarm_fire_i,
    input wire logic ring_i,
    input wire logic low_power_i,
    output logic tx_enable_o,
    // Status indicator and level output
    output logic status_pin_o,
    output logic level_pulse_o,
    // Analog converter front end
    output logic adc_hold_o,
    output logic adc_ch_o,
    input wire logic adc_done_i,
    input wire logic [mss_pkg::ADC_W-1:0] adc_raw_i
);
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [7:0] mode;
        logic [3:0] gout;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic mon_burst;
        logic alarm;
        logic tone_en;
        logic [15:0] tone_half;
        logic [15:0] tone_cnt;
        logic tone;
        logic dac_en;
        logic [9:0] dac_val;
        mss_pkg::mss_adc_t adc_st;
        logic adc_ch;
        logic adc_hold;
        logic [10:0] adc_mv;
        logic adc_valid;
        logic [15:0] tick_cnt;
        logic tick;
        logic [11:0] blink_ms;
        logic lamp_n;
        mss_pkg::mss_mon_t mon_st;
        logic [11:0] mon_ms;
        logic mon;
    } mss_state_t;

    mss_state_t st_r;
    mss_state_t st_nxt;
    logic [3:0] alt_val;
    logic inhibit;
    logic lamp;
    logic [21:0] mv_prod;
    logic [11:0] blink_per;

    // Pad mode of one pad from the packed mode field
    function automatic logic [1:0] pad_mode(input logic [7:0] m,
                                            input int idx);
        pad_mode = m[idx*2 +: 2];
    endfunction

    // Byte-lane merge of a bus write
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        lane_merge = r;
    endfunction

    // Inhibit acts only in the pad's alternate mode
    assign inhibit = (pad_mode(st_r.mode, mss_pkg::PIN_INHIBIT)
                      == mss_pkg::PAD_ALT) && !st_r.sync2[0];
    assign alt_val = {st_r.tone, st_r.alarm, st_r.mon, 1'b0};
    assign mv_prod = 22'(adc_raw_i) * 22'(mss_pkg::ADC_FULL_MV);
    assign blink_per = (net_state_i == mss_pkg::NET_REG) ?
                       mss_pkg::SLOW_PER_MS : mss_pkg::FAST_PER_MS;

    // Lamp pattern from device status
    always_comb begin
        if (!dev_on_i) begin
            lamp = 1'b0;
        end else if (call_active_i) begin
            lamp = 1'b1;
        end else if (net_state_i == mss_pkg::NET_REG) begin
            lamp = st_r.blink_ms < mss_pkg::SLOW_ON_MS;
        end else begin
            lamp = st_r.blink_ms < mss_pkg::FAST_ON_MS;
        end
    end

    // Pad drivers; inhibit pad is never driven in its alternate mode
    generate
        for (genvar i = 0; i < mss_pkg::NPAD; i++) begin : g_pad
            always_comb begin
                case (pad_mode(st_r.mode, i))
                    mss_pkg::PAD_OUT: begin
                        pad_oe_o[i] = 1'b1;
                        pad_o[i] = st_r.gout[i];
                    end
                    mss_pkg::PAD_ALT: begin
                        pad_oe_o[i] = (i != mss_pkg::PIN_INHIBIT);
                        pad_o[i] = alt_val[i];
                    end
                    default: begin
                        pad_oe_o[i] = 1'b0;
                        pad_o[i] = 1'b0;
                    end
                endcase
            end
        end
    endgenerate

    // Next state of the whole block
    always_comb begin
        st_nxt = st_r;
        // Pads are asynchronous: two flops
        st_nxt.sync1 = pad_i;
        st_nxt.sync2 = st_r.sync1;

        // Millisecond tick
        st_nxt.tick = 1'b0;
        if (st_r.tick_cnt >= TICK_LAST) begin
            st_nxt.tick_cnt = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.tick_cnt = st_r.tick_cnt + 16'd1;
        end

        // Blink phase wraps at the pattern period
        if (st_r.tick) begin
            if (st_r.blink_ms >= blink_per - 12'd1) begin
                st_nxt.blink_ms = '0;
            end else begin
                st_nxt.blink_ms = st_r.blink_ms + 12'd1;
            end
        end
        st_nxt.lamp_n = !lamp;

        // Whole-call monitor; bursts are held back during the lead
        case (st_r.mon_st)
            mss_pkg::MON_IDLE: begin
                st_nxt.mon_ms = '0;
                if (call_active_i) begin
                    st_nxt.mon_st = mss_pkg::MON_LEAD;
                end
            end
            mss_pkg::MON_LEAD: begin
                if (st_r.tick) begin
                    st_nxt.mon_ms = st_r.mon_ms + 12'd1;
                end
                if (st_r.mon_ms >= mss_pkg::MON_LEAD_MS) begin
                    st_nxt.mon_st = mss_pkg::MON_CALL;
                    st_nxt.mon_ms = '0;
                end
            end
            mss_pkg::MON_CALL: begin
                st_nxt.mon_ms = '0;
                if (!call_active_i) begin
                    st_nxt.mon_st = mss_pkg::MON_TAIL;
                end
            end
            mss_pkg::MON_TAIL: begin
                // A late burst restarts the tail count
                if (tx_burst_i) begin
                    st_nxt.mon_ms = '0;
                end else if (st_r.tick) begin
                    st_nxt.mon_ms = st_r.mon_ms + 12'd1;
                end
                if (call_active_i) begin
                    st_nxt.mon_st = mss_pkg::MON_CALL;
                end else if (st_r.mon_ms >= mss_pkg::MON_TAIL_MS) begin
                    st_nxt.mon_st = mss_pkg::MON_IDLE;
                end
            end
            default: begin
                st_nxt.mon_st = mss_pkg::MON_IDLE;
            end
        endcase
        if (st_r.mon_burst) begin
            st_nxt.mon = tx_burst_i;
        end else begin
            st_nxt.mon = (st_nxt.mon_st != mss_pkg::MON_IDLE);
        end

        // Tone generator, free while enabled or ringing
        if ((st_r.tone_en || ring_i) && st_r.tone_half != 16'h0000) begin
            if (st_r.tone_cnt >= st_r.tone_half - 16'd1) begin
                st_nxt.tone_cnt = '0;
                st_nxt.tone = !st_r.tone;
            end else begin
                st_nxt.tone_cnt = st_r.tone_cnt + 16'd1;
            end
        end else begin
            st_nxt.tone_cnt = '0;
            st_nxt.tone = 1'b0;
        end

        // Analog conversion sequence
        st_nxt.adc_hold = 1'b0;
        case (st_r.adc_st)
            mss_pkg::ADC_IDLE: begin
            end
            mss_pkg::ADC_CONV: begin
                if (adc_done_i) begin
                    st_nxt.adc_mv = mv_prod[21:11];
                    st_nxt.adc_valid = 1'b1;
                    st_nxt.adc_st = mss_pkg::ADC_IDLE;
                end
            end
            default: begin
                st_nxt.adc_st = mss_pkg::ADC_IDLE;
            end
        endcase

        // Bus: registered ack, write done at ack
        st_nxt.ack = wb_cyc_i && wb_stb_i && !st_r.ack;
        st_nxt.rdata = '0;
        if (st_nxt.ack) begin
            case (wb_adr_i)
                mss_pkg::OFS_MODE: st_nxt.rdata = {24'h000000, st_r.mode};
                mss_pkg::OFS_OUT: st_nxt.rdata = {28'h0000000, st_r.gout};
                mss_pkg::OFS_IN: st_nxt.rdata = {28'h0000000, st_r.sync2};
                mss_pkg::OFS_MON: st_nxt.rdata = {30'h00000000, st_r.mon,
                                                  st_r.mon_burst};
                mss_pkg::OFS_ALARM: st_nxt.rdata = {31'h00000000, st_r.alarm};
                mss_pkg::OFS_TONE: st_nxt.rdata = {15'h0000, st_r.tone_en,
                                                   st_r.tone_half};
                mss_pkg::OFS_DAC: st_nxt.rdata = {15'h0000, st_r.dac_en,
                                                  6'h00, st_r.dac_val};
                mss_pkg::OFS_ADC_CTL: st_nxt.rdata =
                    {(st_r.adc_st == mss_pkg::ADC_CONV), 29'h00000000,
                     st_r.adc_ch, 1'b0};
                mss_pkg::OFS_ADC_RES: st_nxt.rdata = {15'h0000, st_r.adc_valid,
                                                      5'h00, st_r.adc_mv};
                default: st_nxt.rdata = '0;
            endcase
        end
        if (wb_cyc_i && wb_stb_i && wb_we_i && st_r.ack) begin
            case (wb_adr_i)
                mss_pkg::OFS_MODE: begin
                    st_nxt.mode = 8'(lane_merge(32'(st_r.mode), wb_dat_i,
                                                wb_sel_i));
                end
                mss_pkg::OFS_OUT: begin
                    st_nxt.gout = 4'(lane_merge(32'(st_r.gout), wb_dat_i,
                                                wb_sel_i));
                end
                mss_pkg::OFS_MON: begin
                    if (wb_sel_i[0]) begin
                        st_nxt.mon_burst = wb_dat_i[0];
                    end
                end
                mss_pkg::OFS_ALARM: begin
                    // Write one clears; a new alarm below still wins
                    if (wb_sel_i[0] && wb_dat_i[0]) begin
                        st_nxt.alarm = 1'b0;
                    end
                end
                mss_pkg::OFS_TONE: begin
                    if (wb_sel_i[0]) begin
                        st_nxt.tone_half[7:0] = wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        st_nxt.tone_half[15:8] = wb_dat_i[15:8];
                    end
                    if (wb_sel_i[2]) begin
                        st_nxt.tone_en = wb_dat_i[mss_pkg::TONE_EN_BIT];
                    end
                end
                mss_pkg::OFS_DAC: begin
                    // Value and enable land together in one write
                    if (wb_sel_i[0]) begin
                        st_nxt.dac_val[7:0] = wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        st_nxt.dac_val[9:8] = wb_dat_i[9:8];
                    end
                    if (wb_sel_i[2]) begin
                        st_nxt.dac_en = wb_dat_i[mss_pkg::DAC_EN_BIT];
                    end
                end
                mss_pkg::OFS_ADC_CTL: begin
                    if (wb_sel_i[0] && wb_dat_i[mss_pkg::ADC_START_BIT] &&
                        st_r.adc_st == mss_pkg::ADC_IDLE) begin
                        st_nxt.adc_ch = wb_dat_i[mss_pkg::ADC_CH_BIT];
                        st_nxt.adc_hold = 1'b1;
                        st_nxt.adc_valid = 1'b0;
                        st_nxt.adc_st = mss_pkg::ADC_CONV;
                    end
                end
                default: begin
                end
            endcase
        end
        // Alarm set beats a clear in the same cycle
        if (alarm_fire_i) begin
            st_nxt.alarm = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.mode <= mss_pkg::MODE_RST;
            st_r.tone_half <= mss_pkg::TONE_HALF_RST;
            st_r.lamp_n <= 1'b1;
            st_r.sync1 <= 4'hf;
            st_r.sync2 <= 4'hf;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Pulse level output; silenced in the low power state
    mss_level_pulse u_level (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(st_r.dac_en && !low_power_i),
        .value_i(st_r.dac_val),
        .pulse_o(level_pulse_o)
    );

    // Transmitter held off by inhibit and, in whole-call mode, during the monitor lead
    assign tx_enable_o = !inhibit &&
                         (st_r.mon_burst || st_r.mon_st != mss_pkg::MON_LEAD);
    assign status_pin_o = st_r.lamp_n;
    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.rdata;
    assign adc_hold_o = st_r.adc_hold;
    assign adc_ch_o = st_r.adc_ch;
endmodule

// >>> rtl/mss_pkg.sv
// Package: register map, timing and state types
package mss_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_OUT = 8'h04;
    localparam logic [7:0] OFS_IN = 8'h08;
    localparam logic [7:0] OFS_MON = 8'h0c;
    localparam logic [7:0] OFS_ALARM = 8'h10;
    localparam logic [7:0] OFS_TONE = 8'h14;
    localparam logic [7:0] OFS_DAC = 8'h18;
    localparam logic [7:0] OFS_ADC_CTL = 8'h1c;
    localparam logic [7:0] OFS_ADC_RES = 8'h20;
    // Field positions
    localparam int TONE_EN_BIT = 16;
    localparam int DAC_EN_BIT = 16;
    localparam int ADC_START_BIT = 0;
    localparam int ADC_CH_BIT = 1;
    localparam int ADC_BUSY_BIT = 31;
    localparam int ADC_VALID_BIT = 16;
    // Reset values
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [15:0] TONE_HALF_RST = 16'h61a8;
    // Pad modes, two bits per pad
    localparam logic [1:0] PAD_IN = 2'h0;
    localparam logic [1:0] PAD_OUT = 2'h1;
    localparam logic [1:0] PAD_ALT = 2'h2;
    // Pad indices
    localparam int PIN_INHIBIT = 0;
    localparam int PIN_MONITOR = 1;
    localparam int PIN_ALARM = 2;
    localparam int PIN_TONE = 3;
    localparam int NPAD = 4;
    // Timing
    localparam int CLK_HZ = 50_000_000;
    localparam int MS_PER_S = 1000;
    localparam int TICK_CYC = CLK_HZ / MS_PER_S;
    localparam logic [11:0] MON_LEAD_MS = 12'd300;
    localparam logic [11:0] MON_TAIL_MIN_MS = 12'd500;
    localparam logic [11:0] MON_TAIL_MAX_MS = 12'd1000;
    localparam logic [11:0] MON_TAIL_MS =
        12'((MON_TAIL_MIN_MS + MON_TAIL_MAX_MS) / 2);
    localparam logic [11:0] FAST_PER_MS = 12'd1000;
    localparam logic [11:0] FAST_ON_MS = 12'd500;
    localparam logic [11:0] SLOW_PER_MS = 12'd3000;
    localparam logic [11:0] SLOW_ON_MS = 12'd300;
    // Level converter
    localparam int DAC_W = 10;
    localparam logic [DAC_W-1:0] DAC_TOP = 10'h3ff;
    localparam int ADC_W = 11;
    localparam logic [10:0] ADC_FULL_MV = 11'd2000;

    typedef enum logic [1:0] {
        NET_SEARCH = 2'b00,
        NET_REG = 2'b01,
        NET_SHUTDOWN = 2'b10
    } mss_net_t;

    typedef enum logic [1:0] {
        MON_IDLE = 2'b00,
        MON_LEAD = 2'b01,
        MON_CALL = 2'b10,
        MON_TAIL = 2'b11
    } mss_mon_t;

    typedef enum logic [0:0] {
        ADC_IDLE = 1'b0,
        ADC_CONV = 1'b1
    } mss_adc_t;

    // Pad carrier
    typedef struct packed {
        logic o;
        logic oe;
    } mss_pad_t;
endpackage

// >>> rtl/mss_level_pulse.sv
// Pulse-width level output with fixed internal frequency
`timescale 1ns/1ps
module mss_level_pulse (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic [mss_pkg::DAC_W-1:0] value_i,
    output logic pulse_o
);
    typedef struct packed {
        logic [mss_pkg::DAC_W-1:0] cnt;
        logic out;
    } mss_lp_state_t;

    mss_lp_state_t st_r;
    mss_lp_state_t st_nxt;

    // Period of DAC_TOP clocks, high for value clocks
    always_comb begin
        st_nxt = st_r;
        if (st_r.cnt >= mss_pkg::DAC_TOP - 10'd1) begin
            st_nxt.cnt = '0;
        end else begin
            st_nxt.cnt = st_r.cnt + 10'd1;
        end
        st_nxt.out = en_i && (st_r.cnt < value_i);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pulse_o = st_r.out;
endmodule

// >>> dv/mss_adc_model.sv
// Analog front end model answering sample/hold requests
`timescale 1ns/1ps
module mss_adc_model #(
    parameter logic [10:0] RAW0 = 11'h21c,
    parameter logic [10:0] RAW1 = 11'h5a3
) (
    input wire logic clk_i,
    input wire logic hold_i,
    input wire logic ch_i,
    output logic done_o,
    output logic [10:0] raw_o
);
    logic [2:0] cnt_r = 3'h0;
    logic ch_r = 1'b0;
    // Word comes four clocks after the hold pulse
    always_ff @(posedge clk_i) begin
        if (hold_i) begin
            cnt_r <= 3'h5;
            ch_r <= ch_i;
        end else if (cnt_r != 3'h0) begin
            cnt_r <= cnt_r - 3'h1;
        end
    end
    // Word inverted outside done exposes a stale capture
    assign done_o = (cnt_r == 3'h1);
    assign raw_o = (ch_r ? RAW1 : RAW0) ^ {11{!done_o}};
endmodule

// >>> dv/mss_signal_sva.sv
// Port-level assertions for the status signalling block
`timescale 1ns/1ps
module mss_signal_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [mss_pkg::NPAD-1:0] pad_o,
    input wire logic [mss_pkg::NPAD-1:0] pad_oe_o,
    input wire logic dev_on_i,
    input wire logic call_active_i,
    input wire logic status_pin_o,
    input wire logic adc_hold_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Lamp inputs held past the lamp register
    sequence s_off;
        !dev_on_i [*3];
    endsequence
    sequence s_call;
        (dev_on_i && call_active_i) [*3];
    endsequence
    // A completed register write
    sequence s_wr;
        $past(wb_ack_o && wb_we_i);
    endsequence
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    property p_ack_req;
        wb_ack_o |-> wb_cyc_i && wb_stb_i;
    endproperty
    property p_rdata_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    property p_oe_by_write;
        $changed(pad_oe_o) |-> s_wr;
    endproperty
    property p_alarm_hold;
        $fell(pad_o[mss_pkg::PIN_ALARM]) |-> s_wr;
    endproperty
    property p_lamp_off;
        s_off |-> status_pin_o;
    endproperty
    property p_lamp_call;
        s_call |-> !status_pin_o;
    endproperty
    property p_hold_cause;
        $rose(adc_hold_o) |-> $past(wb_ack_o && wb_we_i && wb_dat_i[0]
            && wb_adr_i == mss_pkg::OFS_ADC_CTL);
    endproperty
    property p_hold_pulse;
        adc_hold_o |=> !adc_hold_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held too long");
    a_ack_next: assert property (p_ack_next)
        else $error("ack late");
    a_ack_req: assert property (p_ack_req)
        else $error("ack without request");
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside ack");
    a_oe_by_write: assert property (p_oe_by_write)
        else $error("oe changed without write");
    a_alarm_hold: assert property (p_alarm_hold)
        else $error("alarm fell without clear");
    a_lamp_off: assert property (p_lamp_off)
        else $error("lamp not off");
    a_lamp_call: assert property (p_lamp_call)
        else $error("lamp not on in call");
    a_hold_cause: assert property (p_hold_cause)
        else $error("hold without start");
    a_hold_pulse: assert property (p_hold_pulse)
        else $error("hold too long");
endmodule
bind mss_signal_top mss_signal_sva chk_u (.*);

// >>> dv/tb.sv
// Self-checking bench for the status signalling block
`timescale 1ns/1ps
module tb;
    localparam int TICK = 10;
    localparam logic [10:0] RAW0 = 11'h21c;
    localparam logic [10:0] RAW1 = 11'h5a3;
    logic clk_i = 1'b0, rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf, pad_i = 4'h1, pad_o, pad_oe_o;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, tx_enable_o, status_pin_o, level_pulse_o;
    logic adc_hold_o, adc_ch_o, adc_done_i;
    logic dev_on_i = 1'b1, call_active_i = 1'b0, tx_burst_i = 1'b0;
    logic alarm_fire_i = 1'b0, ring_i = 1'b0, low_power_i = 1'b0;
    logic [1:0] net_state_i = 2'h1;
    logic [10:0] adc_raw_i;
    int n_mismatch = 0, checks_done = 0;
    mss_signal_top #(.TICK_CYC(TICK)) uut (.*);
    mss_adc_model #(.RAW0(RAW0), .RAW1(RAW1)) adc (.clk_i(clk_i),
        .hold_i(adc_hold_o), .ch_i(adc_ch_o), .done_o(adc_done_i),
        .raw_o(adc_raw_i));
    // 50 MHz clock
    always #10 clk_i = ~clk_i;
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            $display("BAD %s exp %h seen %h", s, exp, seen);
            n_mismatch++;
        end
    endtask
    // Classic cycle, released at the ack edge
    task automatic wb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q);
        bit got = 1'b0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (int i = 0; i < 20 && !got; i++) begin
            @(posedge clk_i);
            got = wb_ack_o === 1'b1;
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (!got) begin
            n_mismatch++;
            results();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0, q);
    endtask
    task automatic t_regs();
        logic [31:0] q;
        rd(mss_pkg::OFS_MODE, q);
        chk("mode reset", q, 32'h0);
        rd(8'hfc, q);
        chk("unmapped", q, 32'h0);
        wr(mss_pkg::OFS_MODE, 32'h55);
        wr(mss_pkg::OFS_OUT, 32'ha);
        @(negedge clk_i);
        chk("pad out", {pad_oe_o, pad_o}, 32'hfa);
        wr(mss_pkg::OFS_MODE, 32'h0);
        @(posedge clk_i) pad_i <= 4'h9;
        repeat (4) @(posedge clk_i);
        rd(mss_pkg::OFS_IN, q);
        chk("pad in", {pad_oe_o, q[3:0]}, 32'h09);
        @(posedge clk_i) pad_i <= 4'h1;
        wr(mss_pkg::OFS_MODE, 32'h2);
        @(posedge clk_i) pad_i <= 4'h0;
        repeat (4) @(negedge clk_i);
        chk("tx off", tx_enable_o, 1'b0);
        @(posedge clk_i) pad_i <= 4'h1;
        repeat (4) @(negedge clk_i);
        chk("tx on", tx_enable_o, 1'b1);
        $display("regs done");
    endtask
    task automatic t_mon();
        logic [7:0] pat = 8'hb2;
        logic prev = 1'b0;
        int n;
        wr(mss_pkg::OFS_MON, 32'h1);
        wr(mss_pkg::OFS_MODE, 32'h8);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i) tx_burst_i <= pat[i];
            @(negedge clk_i);
            chk("burst mon", pad_o[1], prev);
            prev = pat[i];
        end
        @(posedge clk_i) tx_burst_i <= 1'b0;
        wr(mss_pkg::OFS_MON, 32'h0);
        @(posedge clk_i) call_active_i <= 1'b1;
        repeat (3) @(negedge clk_i);
        chk("lead", {pad_o[1], tx_enable_o}, 32'h2);
        for (n = 3; tx_enable_o !== 1'b1 && n < 4000; n++) @(negedge clk_i);
        chk("lead time", n >= 2995 && n <= 3015, 1'b1);
        @(posedge clk_i) tx_burst_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        tx_burst_i <= 1'b0;
        call_active_i <= 1'b0;
        @(negedge clk_i);
        chk("call mon", pad_o[1], 1'b1);
        for (n = 0; pad_o[1] === 1'b1 && n < 11000; n++) @(negedge clk_i);
        chk("tail time", n >= 5000 && n <= 10000, 1'b1);
        $display("monitor done");
    endtask
    task automatic run(input logic b, output int n);
        for (n = 0; pad_o[3] === b && n < 100; n++) @(negedge clk_i);
    endtask
    task automatic t_alarm_tone();
        int n;
        wr(mss_pkg::OFS_MODE, 32'ha0);
        @(posedge clk_i) alarm_fire_i <= 1'b1;
        @(posedge clk_i) alarm_fire_i <= 1'b0;
        repeat (20) @(negedge clk_i);
        chk("alarm set", pad_o[2], 1'b1);
        wr(mss_pkg::OFS_ALARM, 32'h1);
        @(negedge clk_i);
        chk("alarm clr", pad_o[2], 1'b0);
        wr(mss_pkg::OFS_TONE, 32'h10005);
        run(1'b1, n);
        run(1'b0, n);
        run(1'b1, n);
        chk("tone high", n, 5);
        run(1'b0, n);
        chk("tone low", n, 5);
        $display("alarm done");
    endtask
    task automatic t_status();
        int n;
        logic [1:0] nets[3] = '{2'h0, 2'h2, 2'h1};
        int per[3] = '{1000, 1000, 3000};
        int on[3] = '{500, 500, 300};
        @(posedge clk_i) dev_on_i <= 1'b0;
        repeat (4) @(negedge clk_i);
        chk("lamp off", status_pin_o, 1'b1);
        @(posedge clk_i) dev_on_i <= 1'b1;
        call_active_i <= 1'b1;
        repeat (4) @(negedge clk_i);
        chk("lamp on", status_pin_o, 1'b0);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_i) net_state_i <= nets[k];
            call_active_i <= 1'b0;
            repeat (20) @(negedge clk_i);
            n = 0;
            repeat (per[k] * TICK) begin
                @(negedge clk_i);
                n += (status_pin_o === 1'b0);
            end
            chk("blink on", n, on[k] * TICK);
        end
        $display("status done");
    endtask
    task automatic t_level_adc();
        int n;
        logic [31:0] q;
        logic [31:0] v[4] = '{32'h10000, 32'h10064, 32'h103ff, 32'h64};
        int hi[4] = '{0, 100, 1023, 0};
        for (int k = 0; k < 4; k++) begin
            wr(mss_pkg::OFS_DAC, v[k]);
            repeat (1100) @(negedge clk_i);
            n = 0;
            repeat (1023) begin
                @(negedge clk_i);
                n += (level_pulse_o === 1'b1);
            end
            chk("level duty", n, hi[k]);
        end
        for (int c = 0; c < 2; c++) begin
            wr(mss_pkg::OFS_ADC_CTL, {30'h0, c[0], 1'b1});
            q = 32'h0;
            for (n = 0; q[16] !== 1'b1 && n < 20; n++) rd(8'h20, q);
            n = c ? RAW1 : RAW0;
            chk("adc mv", q[10:0], (n * 2000) >> 11);
            chk("adc ch", adc_ch_o, c[0]);
        end
        $display("level done");
    endtask
    // Reset, then scenarios
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_mon();
        t_alarm_tone();
        t_status();
        t_level_adc();
        results();
    end
endmodule
